// *** design/dpw_top.sv ***
// Purpose: Two 10-bit pulse-division PWM channels behind an 8-bit register port.
// Assumes: Strobes and low_power_halt come from logic on the same clock.
// Notes:   Half-clock resolution under select 00 is carried between sub-pulses.
`timescale 1ns/100ps
`default_nettype none

module dpw_top (
  input wire logic clock,                        // Block clock phi
  input wire logic rst,                          // Asynchronous reset, active high
  input wire logic [15:0] addr,                  // Register address
  input wire logic [7:0] wdata,                  // Register write data
  input wire logic wr,                           // Write strobe
  input wire logic rd,                           // Read strobe
  output logic [7:0] rdata,                      // Read data, cycle after strobe
  input wire logic [1:0] event_count_waveform,   // Event-counter waveform per channel
  input wire logic low_power_halt,               // High in non-functioning modes
  output logic ch1_output_pin,                   // Channel 1 waveform
  output logic ch2_output_pin,                   // Channel 2 waveform
  output logic [7:0] module_clock_gate_two       // Clock-gate register contents
);

  // Whole block state
  typedef struct packed {
    dpw_pkg::dpw_ch_t [dpw_pkg::NUM_CH-1:0] ch;
    logic [7:0] gate;
    logic [7:0] rdata;
    logic [dpw_pkg::NUM_CH-1:0] pin;
  } dpw_state_t;

  dpw_state_t st_reg;
  dpw_state_t st_next;

  // Address decode shared by the write and read paths
  function automatic dpw_pkg::dpw_reg_t reg_of(input logic [15:0] a, input int c);
    dpw_pkg::dpw_reg_t k;
    k = dpw_pkg::REG_NONE;
    if (a == dpw_pkg::CTRL_ADDR[c]) begin
      k = dpw_pkg::REG_CTRL;
    end else if (a == dpw_pkg::UPPER_ADDR[c]) begin
      k = dpw_pkg::REG_UPPER;
    end else if (a == dpw_pkg::LOWER_ADDR[c]) begin
      k = dpw_pkg::REG_LOWER;
    end else if (a == dpw_pkg::GATE_ADDR) begin
      k = dpw_pkg::REG_GATE;
    end
    return k;
  endfunction

  // Steps of one sub-pulse; remainder steps go to the earliest sub-pulses
  function automatic logic [8:0] share_of(input logic [dpw_pkg::DUTY_W-1:0] d, input logic [1:0] q);
    logic [10:0] total;
    logic extra;
    total = 11'(d) + 11'(dpw_pkg::DUTY_OFFSET);
    extra = (q < total[1:0]);
    return total[10:2] + 9'(extra);
  endfunction

  // Sub-pulse length in half clocks; only select 00 ever leaves an odd one
  function automatic logic [11:0] half_of(input logic [8:0] w, input logic [1:0] s, input logic cy);
    return (12'(w) << s) + 12'(cy);
  endfunction

  // Last count of a sub-period, one less than the sub-period length
  function automatic logic [dpw_pkg::CNT_W-1:0] sub_last_of(input logic [dpw_pkg::SEL_W-1:0] s);
    logic [10:0] len;
    len = 11'(dpw_pkg::STEPS_PER_SUB / 2) << s; // Halve first, so the longest still fits
    return dpw_pkg::CNT_W'(len - 11'h1);
  endfunction

  // Clock select inside the written control bits
  function automatic logic [dpw_pkg::SEL_W-1:0] sel_of(input logic [2:0] ctrl);
    return ctrl[dpw_pkg::CTRL_SEL_LSB +: dpw_pkg::SEL_W];
  endfunction

  // Channel registers that are write-only and answer all ones
  function automatic logic is_wo_reg(input dpw_pkg::dpw_reg_t k);
    return (k == dpw_pkg::REG_CTRL) || (k == dpw_pkg::REG_UPPER) || (k == dpw_pkg::REG_LOWER);
  endfunction

  // Next state of both channels and the register port
  always_comb begin
    dpw_pkg::dpw_ch_t cur;
    dpw_pkg::dpw_ch_t nc;
    dpw_pkg::dpw_reg_t kind;
    logic [8:0] w;
    logic [11:0] h;
    logic [10:0] high_clks;
    logic [dpw_pkg::CNT_W-1:0] sub_last;
    logic run;
    logic wrap;
    logic load;
    cur = '0;
    nc = '0;
    kind = dpw_pkg::REG_NONE;
    w = '0;
    h = '0;
    high_clks = '0;
    sub_last = '0;
    run = 1'b0;
    wrap = 1'b0;
    load = 1'b0;
    st_next = st_reg;
    st_next.rdata = dpw_pkg::UNMAPPED_DATA;

    // Clock-gate register, all eight bits kept for the other modules
    if (wr && addr == dpw_pkg::GATE_ADDR) begin
      st_next.gate = wdata;
    end
    if (rd && addr == dpw_pkg::GATE_ADDR) begin
      st_next.rdata = st_reg.gate;
    end

    for (int c = 0; c < dpw_pkg::NUM_CH; c++) begin
      cur = st_reg.ch[c];
      nc = cur;
      kind = reg_of(addr, c);
      run = st_reg.gate[dpw_pkg::STBY_BIT[c]];

      // Total high steps, shared evenly, remainder to the first sub-pulses
      w = share_of(cur.duty, cur.quarter);

      // Steps are half an input clock: 2^sel half-clocks each
      h = half_of(w, cur.sel, cur.carry);
      high_clks = h[11:1];
      sub_last = sub_last_of(cur.sel);
      wrap = (cur.cnt == sub_last) && (cur.quarter == dpw_pkg::LAST_QUARTER);
      load = !run || wrap;

      // Waveform timing; frozen while the chip is in a halted mode
      if (low_power_halt) begin
        st_next.pin[c] = 1'b0;
      end else if (!run) begin
        nc.cnt = '0;
        nc.quarter = 2'h0;
        nc.carry = 1'b0;
        st_next.pin[c] = 1'b0;
      end else begin
        // Event format copies the event waveform; otherwise each sub-pulse is high for its first high_clks clocks, then low
        if (cur.fmt) begin
          st_next.pin[c] = event_count_waveform[c];
        end else begin
          st_next.pin[c] = (11'(cur.cnt) < high_clks);
        end
        if (cur.cnt == sub_last) begin
          nc.cnt = '0;
          nc.quarter = cur.quarter + 2'h1;
          // Only select 00 can leave half a clock over
          nc.carry = (cur.sel == '0) ? h[0] : 1'b0;
        end else begin
          nc.cnt = cur.cnt + dpw_pkg::CNT_W'(1);
        end
      end

      // Period boundary: take new settings so no period is cut short
      if (!low_power_halt && load) begin
        nc.sel = sel_of(cur.ctrl);
        nc.fmt = cur.ctrl[dpw_pkg::CTRL_FMT_BIT];
        if (sel_of(cur.ctrl) != '0) begin
          nc.carry = 1'b0;
        end
        if (cur.pend) begin
          nc.duty = {cur.upper, cur.lower};
          nc.pend = 1'b0;
        end
      end

      // Register writes; a new upper write beats a same-cycle transfer
      if (wr) begin
        unique case (kind)
          dpw_pkg::REG_CTRL: nc.ctrl = wdata[2:0];
          dpw_pkg::REG_UPPER: begin
            nc.upper = wdata[dpw_pkg::UPPER_DUTY_LSB +: 2];
            nc.pend = 1'b1;
          end
          dpw_pkg::REG_LOWER: nc.lower = wdata;
          dpw_pkg::REG_GATE: ;
          dpw_pkg::REG_NONE: ;
        endcase
      end

      // Write-only registers answer all ones
      if (rd && is_wo_reg(kind)) begin
        st_next.rdata = dpw_pkg::READ_ONES;
      end

      st_next.ch[c] = nc;
    end
  end

  // State register; settings survive every mode but reset, standby clears a channel's counters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < dpw_pkg::NUM_CH; c++) begin
        st_reg.ch[c] <= dpw_pkg::CH_RESET;
      end
      st_reg.gate <= dpw_pkg::GATE_RESET;
      st_reg.rdata <= dpw_pkg::UNMAPPED_DATA;
      st_reg.pin <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign rdata = st_reg.rdata;
  assign ch1_output_pin = st_reg.pin[0];
  assign ch2_output_pin = st_reg.pin[1];
  assign module_clock_gate_two = st_reg.gate;

endmodule

`default_nettype wire

// *** design/dpw_pkg.sv ***
// Purpose: Shared constants and types for the dual pulse-division PWM block.
// Assumes: 8-bit register port with 16-bit addresses; phi is the block clock.
// Notes:   Channel index 0 is channel 1, index 1 is channel 2.
package dpw_pkg;

  // Channel count and widths
  localparam int NUM_CH = 2;
  localparam int DUTY_W = 10;
  localparam int SEL_W = 2;
  localparam int CNT_W = 10;

  // Register addresses, index 0 = channel 1
  localparam logic [1:0][15:0] CTRL_ADDR = {16'hffcd, 16'hffd0};
  localparam logic [1:0][15:0] UPPER_ADDR = {16'hffce, 16'hffd1};
  localparam logic [1:0][15:0] LOWER_ADDR = {16'hffcf, 16'hffd2};
  localparam logic [15:0] GATE_ADDR = 16'hfffb;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'hf8;
  localparam logic [7:0] UPPER_RESET = 8'hfc;
  localparam logic [7:0] LOWER_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'hff;

  // Field positions
  localparam int CTRL_FMT_BIT = 2;
  localparam int CTRL_SEL_LSB = 0;
  localparam int UPPER_DUTY_LSB = 0;
  localparam logic [1:0][2:0] STBY_BIT = {3'h4, 3'h1};

  // Read answers
  localparam logic [7:0] READ_ONES = 8'hff;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // Waveform timing, in resolution steps of half an input clock period
  localparam int STEPS_PER_PERIOD = 1024;
  localparam int SUBPULSES = 4;
  localparam int STEPS_PER_SUB = STEPS_PER_PERIOD / SUBPULSES;
  localparam int DUTY_OFFSET = 4;
  localparam logic [1:0] LAST_QUARTER = 2'h3;

  // Register kinds seen by the decoder
  typedef enum {REG_NONE, REG_CTRL, REG_UPPER, REG_LOWER, REG_GATE} dpw_reg_t;

  // Per-channel state
  typedef struct packed {
    logic [2:0] ctrl;        // Written control bits
    logic [1:0] upper;       // Buffered upper duty bits
    logic [7:0] lower;       // Buffered lower duty byte
    logic pend;              // Upper written, transfer waiting
    logic [DUTY_W-1:0] duty; // Duty used by the generator
    logic [SEL_W-1:0] sel;   // Clock select used by the generator
    logic fmt;               // Output format used by the generator
    logic [CNT_W-1:0] cnt;   // Clock count inside the sub-period
    logic [1:0] quarter;     // Sub-period index
    logic carry;             // Left-over half clock, select 00 only
  } dpw_ch_t;

  localparam dpw_ch_t CH_RESET = '{
    ctrl: CTRL_RESET[2:0], upper: UPPER_RESET[1:0], lower: LOWER_RESET, pend: 1'b0,
    duty: {UPPER_RESET[1:0], LOWER_RESET}, sel: CTRL_RESET[1:0], fmt: CTRL_RESET[CTRL_FMT_BIT],
    cnt: '0, quarter: 2'h0, carry: 1'b0};

endpackage

// *** test/dpw_load.sv ***
// Purpose: Load model standing on both PWM pins.
// Assumes: Pins are sampled on the block clock.
// Notes: Counts high clocks like a filter integrates.
`timescale 1ns/100ps
`default_nettype none
module dpw_load (
  input wire logic clock, // Block clock
  input wire logic win, // Counting window
  input wire logic [1:0] pin, // Pins, bit 0 channel 1
  output logic [1:0][15:0] hi // High clocks per pin
);
  // Window closed clears, so each window starts at zero
  always_ff @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      hi[i] <= win ? hi[i] + 16'(pin[i]) : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** test/dpw_top_assertions.sv ***
// Purpose: Port-level checks of the dual PWM block.
// Assumes: One clock domain, reset active high.
// Notes: Pins are judged only where their level is fixed.
`timescale 1ns/100ps
`default_nettype none
module dpw_top_assertions (
  input wire logic clock, // Block clock
  input wire logic rst, // Reset
  input wire logic [15:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic low_power_halt, // Halt mode
  input wire logic ch1_output_pin, // Pin 1
  input wire logic ch2_output_pin, // Pin 2
  input wire logic [7:0] module_clock_gate_two // Gate
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Read of any channel register
  sequence s_wo_read;
    rd && (addr inside {[16'hffcd:16'hffd2]});
  endsequence
  // Halt seen for two samples, so the pin had time to fall
  sequence s_halted;
    low_power_halt ##1 low_power_halt;
  endsequence
  AST_WO_READ: assert property (s_wo_read |=> rdata == 8'hff)
    else $error("channel register read not all ones");
  AST_GATE_READ: assert property (rd && addr == dpw_pkg::GATE_ADDR |=> rdata == module_clock_gate_two)
    else $error("gate read wrong");
  AST_IDLE_DATA: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not cleared");
  AST_GATE_WRITE: assert property (wr && addr == dpw_pkg::GATE_ADDR |=> module_clock_gate_two == $past(wdata))
    else $error("gate write lost");
  AST_GATE_RESET: assert property ($fell(rst) |-> module_clock_gate_two == 8'hff)
    else $error("gate reset value wrong");
  AST_HALT_LOW: assert property (s_halted |-> !ch1_output_pin && !ch2_output_pin)
    else $error("pin high while halted");
  AST_CH1_STBY: assert property (!module_clock_gate_two[1] |=> !ch1_output_pin)
    else $error("channel 1 pin high in standby");
  AST_CH2_STBY: assert property (!module_clock_gate_two[4] |=> !ch2_output_pin)
    else $error("channel 2 pin high in standby");
endmodule
bind dpw_top dpw_top_assertions i_chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .low_power_halt(low_power_halt), .ch1_output_pin(ch1_output_pin),
  .ch2_output_pin(ch2_output_pin), .module_clock_gate_two(module_clock_gate_two));
`default_nettype wire

// *** test/dpw_top_test.sv ***
// Purpose: Self-checking bench for the dual PWM block.
// Assumes: Duty judged as high clocks over two periods.
// Notes: Two-period windows absorb the half-clock carry.
`timescale 1ns/100ps
`default_nettype none
module dpw_top_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low_power_halt = 1'b0;
  logic win = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [1:0] event_count_waveform = 2'h0;
  logic [7:0] rdata, gate;
  logic ch1, ch2;
  logic [1:0][15:0] hi;
  int miscompares = 0;
  int num_checks = 0;
  dpw_top i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .event_count_waveform(event_count_waveform), .low_power_halt(low_power_halt), .ch1_output_pin(ch1),
    .ch2_output_pin(ch2), .module_clock_gate_two(gate));
  dpw_load i_load (.clock(clock), .win(win), .pin({ch2, ch1}), .hi(hi));
  // 10 MHz block clock
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(logic [15:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(logic [15:0] a, logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check("read data", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic duty(int c, logic [9:0] d);
    wreg(dpw_pkg::LOWER_ADDR[c], d[7:0]);
    wreg(dpw_pkg::UPPER_ADDR[c], {6'h3f, d[9:8]});
  endtask
  task automatic measure(int len, logic [15:0] e1, logic [15:0] e2);
    @(posedge clock);
    win <= 1'b1;
    repeat (len) @(posedge clock);
    win <= 1'b0;
    #1 check("ch1 high clocks", e1, hi[0]);
    check("ch2 high clocks", e2, hi[1]);
  endtask
  // Reset values: undivided clock, duty zero, both channels running
  task automatic t_reset;
    measure(1024, 16'h0004, 16'h0004);
  endtask
  task automatic t_regs;
    for (int c = 0; c < 2; c++) begin
      rreg(dpw_pkg::CTRL_ADDR[c], 8'hff);
      rreg(dpw_pkg::UPPER_ADDR[c], 8'hff);
      rreg(dpw_pkg::LOWER_ADDR[c], 8'hff);
    end
    rreg(16'hffd3, 8'h00);
    rreg(dpw_pkg::GATE_ADDR, 8'hff);
    wreg(dpw_pkg::GATE_ADDR, 8'h5a);
    rreg(dpw_pkg::GATE_ADDR, 8'h5a);
    check("gate output", 16'h005a, {8'h00, gate});
  endtask
  // Every clock select, both channels at once
  task automatic t_sel;
    logic [9:0] d1;
    for (int s = 0; s < 4; s++) begin
      d1 = 10'(s * 10'h0f0);
      wreg(dpw_pkg::CTRL_ADDR[0], 8'(s));
      wreg(dpw_pkg::CTRL_ADDR[1], 8'(s));
      duty(0, d1);
      duty(1, 10'h3f0 - d1);
      // New settings may wait for a boundary a whole new period away
      repeat (576 << s) @(posedge clock);
      measure(1024 << s, 16'(16'(d1) + 16'h0004) << s, 16'(16'h03f4 - 16'(d1)) << s);
    end
  endtask
  task automatic t_standby;
    wreg(dpw_pkg::LOWER_ADDR[0], 8'h00);
    measure(8192, 16'h16a0, 16'h0920);
    wreg(dpw_pkg::GATE_ADDR, 8'hfd);
    measure(8192, 16'h0000, 16'h0920);
    wreg(dpw_pkg::GATE_ADDR, 8'hef);
    measure(8192, 16'h16a0, 16'h0000);
    wreg(dpw_pkg::GATE_ADDR, 8'hff);
  endtask
  // Format change waits for the period boundary
  task automatic t_format;
    wreg(dpw_pkg::CTRL_ADDR[0], 8'h07);
    event_count_waveform <= 2'h1;
    repeat (4200) @(posedge clock);
    measure(8192, 16'h2000, 16'h0920);
    event_count_waveform <= 2'h0;
    wreg(dpw_pkg::CTRL_ADDR[0], 8'h03);
    repeat (4200) @(posedge clock);
  endtask
  task automatic t_halt;
    low_power_halt <= 1'b1;
    measure(8192, 16'h0000, 16'h0000);
    @(posedge clock);
    low_power_halt <= 1'b0;
    measure(8192, 16'h16a0, 16'h0920);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence after 16 reset cycles
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_sel();
    t_standby();
    t_format();
    t_halt();
    finish_test();
  end
  // Watchdog about a fifth beyond the expected run
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
